// file: hw/slld_top.sv
// Purpose: three-wire programming port, latch decode and reference latch fields
// Assumes: serial clock stands still while the load strobe is high
// Notes:   load strobe must stay high for at least two system clock periods
//
// Function
// - one data bit is shifted in on each rising serial clock edge into a 24-bit register.
// - a rising load strobe copies the word into exactly one of four latches.
// - word bit one is the upper select bit and bit zero the lower select bit.
// - select 00 is IF reference, 01 IF N, 10 RF reference and 11 RF N latch.
// - select 00 loads a 14-bit IF reference divide value from the word.
// - IF bits 23..21 are pump current, 20 monitor, 19 lock, 18 three-state, 17 polarity.
// - the IF divide value sits in bits 15..2 with bit 16 unused.
// - the RF reference latch uses the same control bits and a divide value in bits 16..2.
`timescale 1ns/1ps
module slld_top (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              serial_clk,
  input  wire logic                              serial_data,
  input  wire logic                              load_strobe,
  output logic [slld_pkg::PUMP_BITS-1:0]         if_pump_current_code,
  output logic                                   if_monitor_output_select,
  output logic                                   if_lock_detect_enable,
  output logic                                   if_pump_three_state,
  output logic                                   if_polarity_flag,
  output logic [slld_pkg::IF_DIV_BITS-1:0]       if_divide_value,
  output logic [slld_pkg::PUMP_BITS-1:0]         rf_pump_current_code,
  output logic                                   rf_monitor_output_select,
  output logic                                   rf_lock_detect_enable,
  output logic                                   rf_pump_three_state,
  output logic                                   rf_polarity_flag,
  output logic [slld_pkg::RF_DIV_BITS-1:0]       rf_divide_value,
  output logic [slld_pkg::PAYLOAD_BITS-1:0]      if_n_counter_latch,
  output logic [slld_pkg::PAYLOAD_BITS-1:0]      rf_n_counter_latch,
  output logic [1:0]                             last_select,
  output logic                                   load_done
);
  import slld_pkg::*;

  typedef struct packed {
    logic                    strobe_prev;
    slld_control_type        if_control;
    logic [IF_DIV_BITS-1:0]  if_divide;
    slld_control_type        rf_control;
    logic [RF_DIV_BITS-1:0]  rf_divide;
    logic [PAYLOAD_BITS-1:0] if_n;
    logic [PAYLOAD_BITS-1:0] rf_n;
    logic [1:0]              select;
    logic                    done;
  } slld_top_state_type;

  slld_top_state_type   state;
  slld_top_state_type   next_state;
  logic [WORD_BITS-1:0] shift_word;
  logic                 strobe_sync;
  logic                 strobe_rise;
  slld_select_type      word_select;

  // control field layout is common to both reference latches
  function automatic slld_control_type control_fields(input logic [WORD_BITS-1:0] word);
    slld_control_type fields;
    fields.pump_current_code     = word[PUMP_MSB:PUMP_LSB];
    fields.monitor_output_select = word[MONITOR_BIT];
    fields.lock_detect_enable    = word[LOCK_BIT];
    fields.pump_three_state      = word[TRISTATE_BIT];
    fields.polarity_flag         = word[POLARITY_BIT];
    return fields;
  endfunction

  slld_shifter u_shifter (
    .serial_clk  (serial_clk),
    .rst_b       (rst_b),
    .serial_data (serial_data),
    .shift_word  (shift_word)
  );

  slld_sync u_strobe_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (load_strobe),
    .sync_out (strobe_sync)
  );

  assign strobe_rise = strobe_sync & ~state.strobe_prev;
  assign word_select = slld_select_type'({shift_word[SEL_UPPER_BIT],
                                          shift_word[SEL_LOWER_BIT]});

  // shift_word is read across domains without a second sync: the serial clock is
  // idle while the strobe is high, so the word is static when it is sampled here
  always_comb begin
    next_state             = state;
    next_state.strobe_prev = strobe_sync;
    next_state.done        = 1'h0;
    if (strobe_rise) begin
      next_state.done   = 1'h1;
      next_state.select = word_select;
      unique case (word_select)
        SEL_IF_REFERENCE: begin
          next_state.if_control = control_fields(shift_word);
          next_state.if_divide  = shift_word[IF_DIV_MSB:DIV_LSB];
        end
        SEL_IF_N_COUNTER: begin
          next_state.if_n = shift_word[PAYLOAD_MSB:PAYLOAD_LSB];
        end
        SEL_RF_REFERENCE: begin
          next_state.rf_control = control_fields(shift_word);
          next_state.rf_divide  = shift_word[RF_DIV_MSB:DIV_LSB];
        end
        SEL_RF_N_COUNTER: begin
          next_state.rf_n = shift_word[PAYLOAD_MSB:PAYLOAD_LSB];
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{strobe_prev: RESET_BIT,
                 if_control:  RESET_CONTROL,
                 if_divide:   RESET_PAYLOAD[IF_DIV_BITS-1:0],
                 rf_control:  RESET_CONTROL,
                 rf_divide:   RESET_PAYLOAD[RF_DIV_BITS-1:0],
                 if_n:        RESET_PAYLOAD,
                 rf_n:        RESET_PAYLOAD,
                 select:      SEL_IF_REFERENCE,
                 done:        RESET_BIT};
    end else begin
      state <= next_state;
    end
  end

  assign if_pump_current_code     = state.if_control.pump_current_code;
  assign if_monitor_output_select = state.if_control.monitor_output_select;
  assign if_lock_detect_enable    = state.if_control.lock_detect_enable;
  assign if_pump_three_state      = state.if_control.pump_three_state;
  assign if_polarity_flag         = state.if_control.polarity_flag;
  assign if_divide_value          = state.if_divide;
  assign rf_pump_current_code     = state.rf_control.pump_current_code;
  assign rf_monitor_output_select = state.rf_control.monitor_output_select;
  assign rf_lock_detect_enable    = state.rf_control.lock_detect_enable;
  assign rf_pump_three_state      = state.rf_control.pump_three_state;
  assign rf_polarity_flag         = state.rf_control.polarity_flag;
  assign rf_divide_value          = state.rf_divide;
  assign if_n_counter_latch       = state.if_n;
  assign rf_n_counter_latch       = state.rf_n;
  assign last_select              = state.select;
  assign load_done                = state.done;
endmodule

// file: hw/slld_pkg.sv
// Purpose: shared constants and types of the serial load latch decode block
// Assumes: 24-bit programming word, shifted in msb first
// Notes:   field positions are bit numbers within the shifted word
package slld_pkg;

  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned SEL_UPPER_BIT = 1;
  localparam int unsigned SEL_LOWER_BIT = 0;
  localparam int unsigned PUMP_MSB      = 23;
  localparam int unsigned PUMP_LSB      = 21;
  localparam int unsigned MONITOR_BIT   = 20;
  localparam int unsigned LOCK_BIT      = 19;
  localparam int unsigned TRISTATE_BIT  = 18;
  localparam int unsigned POLARITY_BIT  = 17;
  localparam int unsigned RF_DIV_MSB    = 16;
  localparam int unsigned IF_DIV_MSB    = 15;
  localparam int unsigned DIV_LSB       = 2;
  localparam int unsigned PAYLOAD_MSB   = 23;
  localparam int unsigned PAYLOAD_LSB   = 2;

  localparam int unsigned PAYLOAD_BITS  = PAYLOAD_MSB - PAYLOAD_LSB + 1;
  localparam int unsigned IF_DIV_BITS   = IF_DIV_MSB - DIV_LSB + 1;
  localparam int unsigned RF_DIV_BITS   = RF_DIV_MSB - DIV_LSB + 1;
  localparam int unsigned PUMP_BITS     = PUMP_MSB - PUMP_LSB + 1;

  localparam logic [WORD_BITS-1:0]    RESET_WORD    = 24'h000000;
  localparam logic [PAYLOAD_BITS-1:0] RESET_PAYLOAD = 22'h000000;
  localparam logic                    RESET_BIT     = 1'h0;

  typedef enum logic [1:0] {
    SEL_IF_REFERENCE = 2'h0,
    SEL_IF_N_COUNTER = 2'h1,
    SEL_RF_REFERENCE = 2'h2,
    SEL_RF_N_COUNTER = 2'h3
  } slld_select_type;

  typedef struct packed {
    logic [PUMP_BITS-1:0] pump_current_code;
    logic                 monitor_output_select;
    logic                 lock_detect_enable;
    logic                 pump_three_state;
    logic                 polarity_flag;
  } slld_control_type;

  localparam slld_control_type RESET_CONTROL = 7'h00;

endpackage

// file: hw/slld_sync.sv
// Purpose: two-flop level synchroniser into the system clock
// Assumes: input is a slow level from another domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module slld_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  import slld_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } slld_sync_state_type;

  slld_sync_state_type state;
  slld_sync_state_type next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{stage1: RESET_BIT, stage2: RESET_BIT};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;
endmodule

// file: hw/slld_shifter.sv
// Purpose: serial input shift register on the link clock
// Assumes: data is stable around each rising serial clock edge
// Notes:   keeps only the newest 24 bits, older bits fall off the top
`timescale 1ns/1ps
module slld_shifter (
  input  wire logic                          serial_clk,
  input  wire logic                          rst_b,
  input  wire logic                          serial_data,
  output logic [slld_pkg::WORD_BITS-1:0]     shift_word
);
  import slld_pkg::*;

  typedef struct packed {
    logic [WORD_BITS-1:0] word;
  } slld_shift_state_type;

  slld_shift_state_type state;
  slld_shift_state_type next_state;

  // msb first: the last bit shifted lands in bit zero
  always_comb begin
    next_state      = state;
    next_state.word = {state.word[WORD_BITS-2:0], serial_data};
  end

  always_ff @(posedge serial_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{word: RESET_WORD};
    end else begin
      state <= next_state;
    end
  end

  assign shift_word = state.word;
endmodule

// file: dv/slld_top_asserts.sv
// Purpose: port checks of load timing and latch selection
// Assumes: strobe held high for four clocks, no shifting meanwhile
// Notes:   a reload with an unchanged value is not seen by the hold checks
`timescale 1ns/1ps
module slld_top_chk (
  input wire logic                               clk,
  input wire logic                               rst_b,
  input wire logic                               load_strobe,
  input wire logic [slld_pkg::IF_DIV_BITS-1:0]   if_divide_value,
  input wire logic [slld_pkg::RF_DIV_BITS-1:0]   rf_divide_value,
  input wire logic [slld_pkg::PAYLOAD_BITS-1:0]  if_n_counter_latch,
  input wire logic [slld_pkg::PAYLOAD_BITS-1:0]  rf_n_counter_latch,
  input wire logic [1:0]                         last_select,
  input wire logic                               load_done
);
  import slld_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_done_pulse; load_done |=> !load_done; endproperty
  property p_strobe_done; $rose(load_strobe) |-> ##[2:4] load_done; endproperty
  property p_done_cause; load_done |-> $past(load_strobe, 2); endproperty
  property p_if_hold; !$stable(if_divide_value) |-> load_done && last_select == SEL_IF_REFERENCE;
  endproperty
  property p_rf_hold; !$stable(rf_divide_value) |-> load_done && last_select == SEL_RF_REFERENCE;
  endproperty
  property p_ifn_hold;
    !$stable(if_n_counter_latch) |-> load_done && last_select == SEL_IF_N_COUNTER;
  endproperty
  property p_rfn_hold;
    !$stable(rf_n_counter_latch) |-> load_done && last_select == SEL_RF_N_COUNTER;
  endproperty
  property p_sel_hold; !$stable(last_select) |-> load_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("load_done too long");
  a_strobe_done: assert property (p_strobe_done) else $error("strobe not loaded");
  a_done_cause: assert property (p_done_cause) else $error("load without strobe");
  a_if_hold: assert property (p_if_hold) else $error("IF divide changed");
  a_rf_hold: assert property (p_rf_hold) else $error("RF divide changed");
  a_ifn_hold: assert property (p_ifn_hold) else $error("IF N latch changed");
  a_rfn_hold: assert property (p_rfn_hold) else $error("RF N latch changed");
  a_sel_hold: assert property (p_sel_hold) else $error("select changed");
  c_if_ref: cover property (load_done && last_select == SEL_IF_REFERENCE);
  c_if_n: cover property (load_done && last_select == SEL_IF_N_COUNTER);
  c_rf_ref: cover property (load_done && last_select == SEL_RF_REFERENCE);
  c_rf_n: cover property (load_done && last_select == SEL_RF_N_COUNTER);
endmodule
bind slld_top slld_top_chk i_chk (.clk, .rst_b, .load_strobe, .if_divide_value,
  .rf_divide_value, .if_n_counter_latch, .rf_n_counter_latch, .last_select, .load_done);

// file: dv/slld_host.sv
// Purpose: host controller model on the three-wire programming port
// Assumes: link clock of 64 ns, standing low between words
// Notes:   data shows the inverse of its last bit outside a word
`timescale 1ns/1ps
module slld_host (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      load_strobe
);
  initial begin
    serial_clk = 1'h0;
    serial_data = 1'h0;
    load_strobe = 1'h0;
  end
  // data moves on the falling link edge so hold time is kept
  task automatic shift_word(input logic [23:0] w);
    #7;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #32 serial_clk = 1'h1;
      #32 serial_clk = 1'h0;
    end
    serial_data = ~w[0];
  endtask
  // four clocks high covers the sync delay, three low before the next rise
  task automatic load_word();
    #50;
    @(negedge clk) load_strobe = 1'h1;
    repeat (4) @(negedge clk);
    load_strobe = 1'h0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// file: dv/test_slld_top.sv
// Purpose: self-checking bench of the serial load latch decode block
// Assumes: host model shifts words and raises the load strobe
// Notes:   all latches start at zero after reset
`timescale 1ns/1ps
module test_slld_top;
  import slld_pkg::*;
  logic                    clk = 1'h0;
  logic                    rst_b = 1'h0;
  logic                    serial_clk, serial_data, load_strobe, load_done;
  logic [PUMP_BITS-1:0]    if_pump_current_code, rf_pump_current_code;
  logic                    if_monitor_output_select, if_lock_detect_enable;
  logic                    if_pump_three_state, if_polarity_flag;
  logic                    rf_monitor_output_select, rf_lock_detect_enable;
  logic                    rf_pump_three_state, rf_polarity_flag;
  logic [IF_DIV_BITS-1:0]  if_divide_value;
  logic [RF_DIV_BITS-1:0]  rf_divide_value;
  logic [PAYLOAD_BITS-1:0] if_n_counter_latch, rf_n_counter_latch;
  logic [1:0]              last_select;
  int                      n_errors = 0;
  int                      samples_checked = 0;
  int                      n_loads = 0;
  always #25 clk = ~clk;
  // done stands one whole cycle, so each pulse is seen by exactly one falling edge
  always @(negedge clk) begin
    if (load_done === 1'h1) n_loads++;
  end
  slld_host i_host (.clk, .serial_clk, .serial_data, .load_strobe);
  slld_top i_dut (.clk, .rst_b, .serial_clk, .serial_data, .load_strobe, .if_pump_current_code,
    .if_monitor_output_select, .if_lock_detect_enable, .if_pump_three_state, .if_polarity_flag,
    .if_divide_value, .rf_pump_current_code, .rf_monitor_output_select, .rf_lock_detect_enable,
    .rf_pump_three_state, .rf_polarity_flag, .rf_divide_value, .if_n_counter_latch,
    .rf_n_counter_latch, .last_select, .load_done);
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_if(input logic [2:0] p, input logic [3:0] f, input logic [13:0] d);
    logic [3:0] flags;
    flags = {if_monitor_output_select, if_lock_detect_enable, if_pump_three_state,
             if_polarity_flag};
    chk("if_pump", if_pump_current_code, p);
    chk("if_flags", flags, f);
    chk("if_div", if_divide_value, d);
  endtask
  task automatic chk_rf(input logic [2:0] p, input logic [3:0] f, input logic [14:0] d);
    logic [3:0] flags;
    flags = {rf_monitor_output_select, rf_lock_detect_enable, rf_pump_three_state,
             rf_polarity_flag};
    chk("rf_pump", rf_pump_current_code, p);
    chk("rf_flags", flags, f);
    chk("rf_div", rf_divide_value, d);
  endtask
  task automatic chk_n(input logic [21:0] a, input logic [21:0] b, input logic [1:0] s);
    chk("if_n", if_n_counter_latch, a);
    chk("rf_n", rf_n_counter_latch, b);
    chk("last_select", last_select, s);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // five words and four loads take about 10 us, so 100 us means a hang
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
    chk_if(3'h0, 4'h0, 14'h0000);
    chk_n(22'h000000, 22'h000000, 2'h0);
    // IF word with the unused bit 16 set
    i_host.shift_word({3'h5, 4'hA, 1'h1, 14'h2A5C, 2'h0});
    chk_if(3'h0, 4'h0, 14'h0000);
    chk("load_count", 24'(n_loads), 24'h000000);
    i_host.load_word();
    chk_if(3'h5, 4'hA, 14'h2A5C);
    chk_rf(3'h0, 4'h0, 15'h0000);
    chk("load_count", 24'(n_loads), 24'h000001);
    i_host.shift_word({3'h3, 4'h5, 15'h4ABC, 2'h2});
    i_host.load_word();
    chk_rf(3'h3, 4'h5, 15'h4ABC);
    chk_if(3'h5, 4'hA, 14'h2A5C);
    // stale bits ahead of the word must drop out
    i_host.shift_word(24'hFFFFFF);
    i_host.shift_word({22'h3ABCDE, 2'h1});
    i_host.load_word();
    chk_n(22'h3ABCDE, 22'h000000, 2'h1);
    i_host.shift_word({22'h155AA5, 2'h3});
    i_host.load_word();
    chk_n(22'h3ABCDE, 22'h155AA5, 2'h3);
    chk_rf(3'h3, 4'h5, 15'h4ABC);
    chk("load_count", 24'(n_loads), 24'h000004);
    report_and_stop();
  end
endmodule
